/* include/ppbc_link_if.sv */
// Crossing between the system-clock core and the clocked serial shifter.
// Assumes tx_byte stays still while a clocked byte is on the wire.
`timescale 1ns/100ps
`default_nettype none
interface ppbc_link_if;
  logic [7:0] tx_byte; // Held by core, read by link
  logic [7:0] rx_hold; // Held by link until next byte
  logic done_tgl; // Toggles once per finished byte
  modport core (output tx_byte, input rx_hold, input done_tgl);
  modport link (input tx_byte, output rx_hold, output done_tgl);
endinterface
`default_nettype wire

/* include/ppbc_pkg.sv */
// Shared constants of the programming port: register map, field
// positions, reset values, startup modes and bit timing.
// Assumes a 100 MHz system clock and byte addresses on the register port.
package ppbc_pkg;
  // Register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;
  localparam logic [7:0] TXD_ADDR = 8'h08;
  localparam logic [7:0] RXD_ADDR = 8'h0C;
  localparam logic [7:0] BAUD_ADDR = 8'h10;
  localparam logic [7:0] PINS_ADDR = 8'h14;
  // Control field positions
  localparam int CTRL_SYNC = 0;
  localparam int CTRL_MASTER = 1;
  localparam int CTRL_SEVEN = 2;
  localparam int CTRL_ADDR_EN = 3;
  localparam int CTRL_SEL_LO = 4;
  localparam int CTRL_GPO = 6;
  localparam int CTRL_CK_OE = 7;
  localparam int CTRL_CK_OUT = 8;
  localparam int CTRL_W = 9;
  // Status field positions
  localparam int ST_BUSY = 0;
  localparam int ST_RXFULL = 1;
  localparam int ST_PROG = 2;
  localparam int ST_MODE_LO = 3;
  localparam int ST_RXADDR = 5;
  localparam int ST_FERR = 6;
  // Reset values
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam logic [15:0] BAUD_RST = 16'h0008;
  // Timing
  localparam longint CLK_HZ = 100_000_000;
  localparam longint BOOT_BPS = 2400;
  localparam int BOOT_DIV = int'(CLK_HZ / BOOT_BPS);
  localparam logic [15:0] MIN_DIV = 16'h0008;
  localparam logic [1:0] CAP_WAIT = 2'h3;
  // Startup-mode pair {bit1, bit0}
  typedef enum logic [1:0] {
    BOOT_ZERO = 2'b00,
    BOOT_SLAVE = 2'b01,
    BOOT_CLOCKED = 2'b10,
    BOOT_ASYNC = 2'b11
  } ppbc_boot_e;
  // Status pin functions
  typedef enum logic [1:0] {
    SEL_FETCH = 2'b00,
    SEL_INTACK = 2'b01,
    SEL_GPO = 2'b10
  } ppbc_sel_e;
endpackage

/* logic/ppbc_port.sv */
// Programming and debug port: serial channel, startup-mode capture,
// status pin and external reset. Assumes the core's fetch and ack
// strobes are on clk; the clock pin level arrives as link_clk.
//
// Behaviour
// - Asynchronous bit rate never exceeds the system clock over 8.
// - Asynchronous characters carry 7 or 8 data bits by setting.
// - An optional ninth bit marks the first byte of a message.
// - In run mode software picks asynchronous or clocked operation.
// - Clocked mode shifts on a clock line driven by either end.
// - After reset the port selects cold boot or start at zero.
// - Startup pins are caught at reset; both high mean program mode.
// - Fetch function drives status low on the first opcode fetch.
// - Ack function drives status low through interrupt acknowledge.
// - General-purpose function holds the level software wrote.
// - Low external reset hard-resets the core and peripherals.
// - In asynchronous mode the clock line is a general pin.
// - Startup pins read as inputs and status works as an output.
// - Download and debug are accepted in program mode only.
// - Pair 00 zero, 01 slave, 10 clocked, 11 async at 2400 bps.
`timescale 1ns/100ps
`default_nettype none
module ppbc_port #(
  parameter int BOOT_DIV = ppbc_pkg::BOOT_DIV
) (
  // System clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Serial pins
  input wire logic rxd,
  output logic txd,
  input wire logic link_clk,
  output logic sclk_o,
  output logic sclk_oe,
  // Startup, reset and status pins
  input wire logic startup_mode_bit0,
  input wire logic startup_mode_bit1,
  input wire logic reset_in_n,
  output logic status_o,
  output logic periph_reset,
  // Core side
  input wire logic opcode_fetch,
  input wire logic intack,
  output logic [1:0] boot_src,
  output logic program_mode,
  output logic debug_en
);
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } ppbc_rx_e;

  // Data bits plus optional address bit per character
  function automatic logic [3:0] ppbc_nbits(input logic seven,
                                            input logic aen);
    ppbc_nbits = (seven ? 4'h7 : 4'h8) + {3'h0, aen};
  endfunction

  // Character frame, LSB first, start bit at bit 0
  function automatic logic [10:0] ppbc_frame(input logic [8:0] d,
                                             input logic seven,
                                             input logic aen);
    logic [9:0] body;
    body = aen ? {1'b1, d[8], d[7:0]} : {2'b11, d[7:0]};
    if (seven) begin
      body = aen ? {2'b11, d[8], d[6:0]} : {3'b111, d[6:0]};
    end
    ppbc_frame = {body, 1'b0};
  endfunction

  ppbc_link_if lk ();

  logic [8:0] ctrl_reg;
  logic [15:0] baud_reg;
  logic [8:0] txw_reg;
  logic [8:0] rxw_reg;
  logic rx_full_reg;
  logic ferr_reg;
  logic busy_reg;
  logic [1:0] mode_reg;
  logic [1:0] cap_reg;
  logic first_done_reg;
  logic status_reg;
  logic prst_reg;
  logic [1:0] rst_sync_reg;
  logic [1:0] m0_sync_reg;
  logic [1:0] m1_sync_reg;
  logic [1:0] rx_sync_reg;
  logic [1:0] ck_sync_reg;
  logic [2:0] tg_sync_reg;
  logic [10:0] tx_sh_reg;
  logic [3:0] tx_left_reg;
  logic [15:0] tx_tm_reg;
  ppbc_rx_e rx_st_reg;
  ppbc_rx_e rx_st_next;
  logic [15:0] rx_tm_reg;
  logic [3:0] rx_left_reg;
  logic [8:0] rx_sh_reg;
  logic [15:0] ck_tm_reg;
  logic [4:0] ck_half_reg;
  logic ck_drv_reg;
  logic [31:0] rdata_reg;

  ////////////////////////////////////////////////////////////////////
  // Decode and selection
  wire ext_rst = ~rst_sync_reg[1];
  wire wr_ctrl = wr && (addr == ppbc_pkg::CTRL_ADDR);
  wire wr_baud = wr && (addr == ppbc_pkg::BAUD_ADDR);
  wire wr_tx = wr && (addr == ppbc_pkg::TXD_ADDR);
  wire rd_rx = rd && (addr == ppbc_pkg::RXD_ADDR);
  wire prog = (mode_reg == ppbc_pkg::BOOT_ASYNC);
  // Clocked mode only once running; the host talks async
  wire sync_en = ctrl_reg[ppbc_pkg::CTRL_SYNC] && !prog;
  wire master = ctrl_reg[ppbc_pkg::CTRL_MASTER];
  wire seven = ctrl_reg[ppbc_pkg::CTRL_SEVEN];
  wire aen = ctrl_reg[ppbc_pkg::CTRL_ADDR_EN];
  wire [1:0] sel = ctrl_reg[ppbc_pkg::CTRL_SEL_LO +: 2];
  // Clamp keeps the rate at or below clk / 8
  wire [15:0] div = (baud_reg < ppbc_pkg::MIN_DIV) ?
                    ppbc_pkg::MIN_DIV : baud_reg;
  wire [3:0] nbits = ppbc_nbits(seven, aen);
  wire tx_start = wr_tx && !busy_reg;
  wire byte_done = tg_sync_reg[2] ^ tg_sync_reg[1];
  wire tx_tick = (tx_tm_reg == 16'h0001);
  wire rx_tick = (rx_tm_reg == 16'h0001);
  wire ck_tick = (ck_tm_reg == 16'h0001);
  wire rx_low = !rx_sync_reg[1];

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stages feed only the second stages
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rst_sync_reg <= 2'b00;
      m0_sync_reg <= 2'b00;
      m1_sync_reg <= 2'b00;
      rx_sync_reg <= 2'b11;
      ck_sync_reg <= 2'b00;
      tg_sync_reg <= 3'b000;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], reset_in_n};
      m0_sync_reg <= {m0_sync_reg[0], startup_mode_bit0};
      m1_sync_reg <= {m1_sync_reg[0], startup_mode_bit1};
      rx_sync_reg <= {rx_sync_reg[0], rxd};
      ck_sync_reg <= {ck_sync_reg[0], link_clk};
      tg_sync_reg <= {tg_sync_reg[1:0], lk.done_tgl};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Hard reset of the peripherals while the reset pin is low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prst_reg <= 1'b1;
    end else begin
      prst_reg <= ext_rst;
    end
  end

  // Catch the startup pair once the synchronisers have settled
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cap_reg <= ppbc_pkg::CAP_WAIT;
      mode_reg <= ppbc_pkg::BOOT_ZERO;
    end else if (ext_rst) begin
      cap_reg <= ppbc_pkg::CAP_WAIT;
    end else if (cap_reg != 2'h0) begin
      cap_reg <= cap_reg - 2'h1;
      if (cap_reg == 2'h1) begin
        mode_reg <= {m1_sync_reg[1], m0_sync_reg[1]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control and baud registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= ppbc_pkg::CTRL_RST;
    end else if (ext_rst) begin
      ctrl_reg <= ppbc_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= wdata[ppbc_pkg::CTRL_W-1:0];
    end
  end

  // Async boot rate loads when the pair is caught as 11
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      baud_reg <= ppbc_pkg::BAUD_RST;
    end else if (ext_rst) begin
      baud_reg <= ppbc_pkg::BAUD_RST;
    end else if (cap_reg == 2'h1 && m0_sync_reg[1] && m1_sync_reg[1]) begin
      baud_reg <= BOOT_DIV[15:0];
    end else if (wr_baud) begin
      baud_reg <= wdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Transmit word and busy; a write while busy is dropped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txw_reg <= 9'h000;
      busy_reg <= 1'b0;
    end else if (ext_rst) begin
      busy_reg <= 1'b0;
    end else if (tx_start) begin
      txw_reg <= wdata[8:0];
      busy_reg <= 1'b1;
    end else if (sync_en ? byte_done : (tx_left_reg == 4'h0)) begin
      busy_reg <= 1'b0;
    end
  end
  assign lk.tx_byte = txw_reg[7:0];

  // Async transmitter: one slot per divider period
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_sh_reg <= 11'h7FF;
      tx_left_reg <= 4'h0;
      tx_tm_reg <= 16'h0000;
    end else if (ext_rst) begin
      tx_sh_reg <= 11'h7FF;
      tx_left_reg <= 4'h0;
    end else if (tx_start && !sync_en) begin
      tx_sh_reg <= ppbc_frame(wdata[8:0], seven, aen);
      tx_left_reg <= nbits + 4'h2;
      tx_tm_reg <= div;
    end else if (tx_left_reg != 4'h0) begin
      tx_tm_reg <= tx_tick ? div : tx_tm_reg - 16'h0001;
      if (tx_tick) begin
        tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
        tx_left_reg <= tx_left_reg - 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Async receiver: start check at half a bit, then one per bit
  always_comb begin
    rx_st_next = rx_st_reg;
    case (rx_st_reg)
      RX_IDLE: if (rx_low && !sync_en) rx_st_next = RX_START;
      RX_START: if (rx_tick) rx_st_next = rx_low ? RX_DATA : RX_IDLE;
      RX_DATA: if (rx_tick && rx_left_reg == 4'h1) rx_st_next = RX_STOP;
      RX_STOP: if (rx_tick) rx_st_next = RX_IDLE;
      default: rx_st_next = RX_IDLE;
    endcase
  end

  // Receiver state, timer and shift register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_st_reg <= RX_IDLE;
      rx_tm_reg <= 16'h0000;
      rx_left_reg <= 4'h0;
      rx_sh_reg <= 9'h000;
    end else if (ext_rst) begin
      rx_st_reg <= RX_IDLE;
    end else begin
      rx_st_reg <= rx_st_next;
      if (rx_st_reg == RX_IDLE) begin
        rx_tm_reg <= {1'b0, div[15:1]};
        rx_left_reg <= nbits;
      end else if (rx_tick) begin
        rx_tm_reg <= div;
        if (rx_st_reg == RX_DATA) begin
          rx_sh_reg <= {rx_sync_reg[1], rx_sh_reg[8:1]};
          rx_left_reg <= rx_left_reg - 4'h1;
        end
      end else begin
        rx_tm_reg <= rx_tm_reg - 16'h0001;
      end
    end
  end

  // Align a received character; the address bit arrives last
  wire [7:0] rx_dat = aen ? (seven ? {1'b0, rx_sh_reg[7:1]}
                                   : rx_sh_reg[7:0])
                          : (seven ? {1'b0, rx_sh_reg[8:2]}
                                   : rx_sh_reg[8:1]);
  wire [8:0] rx_word = {aen & rx_sh_reg[8], rx_dat};
  wire rx_stop_ok = (rx_st_reg == RX_STOP) && rx_tick && !rx_low;
  wire rx_stop_bad = (rx_st_reg == RX_STOP) && rx_tick && rx_low;
  wire rx_put = rx_stop_ok || (sync_en && byte_done);

  ////////////////////////////////////////////////////////////////////
  // Receive buffer; a new byte wins over the clearing read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxw_reg <= 9'h000;
      rx_full_reg <= 1'b0;
      ferr_reg <= 1'b0;
    end else if (ext_rst) begin
      rx_full_reg <= 1'b0;
      ferr_reg <= 1'b0;
    end else begin
      if (rx_put) begin
        rxw_reg <= sync_en ? {1'b0, lk.rx_hold} : rx_word;
      end
      rx_full_reg <= rx_put || (rx_full_reg && !rd_rx);
      ferr_reg <= rx_stop_bad || (ferr_reg && !rd_rx);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Clock generator when this end drives the clocked link:
  // sixteen half periods, idle low, stops on its own
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ck_tm_reg <= 16'h0000;
      ck_half_reg <= 5'h00;
      ck_drv_reg <= 1'b0;
    end else if (ext_rst) begin
      ck_half_reg <= 5'h00;
      ck_drv_reg <= 1'b0;
    end else if (tx_start && sync_en && master) begin
      ck_tm_reg <= div;
      ck_half_reg <= 5'h10;
    end else if (ck_half_reg != 5'h00) begin
      ck_tm_reg <= ck_tick ? div : ck_tm_reg - 16'h0001;
      if (ck_tick) begin
        ck_drv_reg <= ~ck_drv_reg;
        ck_half_reg <= ck_half_reg - 5'h01;
      end
    end
  end

  logic lk_txd;
  logic lk_rst_reg;
  // Held outside clocked mode so clock-pin toggles miscount nothing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lk_rst_reg <= 1'b1;
    end else begin
      lk_rst_reg <= !sync_en;
    end
  end

  ppbc_shift u_shift (
    .link_clk(link_clk),
    .reset(lk_rst_reg),
    .rxd(rxd),
    .txd(lk_txd),
    .lk(lk)
  );

  ////////////////////////////////////////////////////////////////////
  // Serial pin drive; clock pin falls back to a plain pin in async
  assign txd = sync_en ? lk_txd : tx_sh_reg[0];
  assign sclk_oe = sync_en ? master
                           : ctrl_reg[ppbc_pkg::CTRL_CK_OE];
  assign sclk_o = sync_en ? ck_drv_reg
                          : ctrl_reg[ppbc_pkg::CTRL_CK_OUT];

  ////////////////////////////////////////////////////////////////////
  // Status pin, one cycle behind the core strobes it reflects
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      first_done_reg <= 1'b0;
      status_reg <= 1'b1;
    end else if (ext_rst) begin
      first_done_reg <= 1'b0;
      status_reg <= 1'b1;
    end else begin
      if (opcode_fetch) begin
        first_done_reg <= 1'b1;
      end
      case (sel)
        ppbc_pkg::SEL_FETCH:
          status_reg <= !(opcode_fetch && !first_done_reg);
        ppbc_pkg::SEL_INTACK: status_reg <= !intack;
        ppbc_pkg::SEL_GPO:
          status_reg <= ctrl_reg[ppbc_pkg::CTRL_GPO];
        default: status_reg <= 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero
  wire [31:0] st_word = {25'h0, ferr_reg, rxw_reg[8], mode_reg,
                         prog, rx_full_reg, busy_reg};
  wire [31:0] pin_word = {29'h0, ck_sync_reg[1], m1_sync_reg[1],
                          m0_sync_reg[1]};
  wire [31:0] rd_mux =
    (addr == ppbc_pkg::CTRL_ADDR) ? {23'h0, ctrl_reg} :
    (addr == ppbc_pkg::STAT_ADDR) ? st_word :
    (addr == ppbc_pkg::RXD_ADDR) ? {23'h0, rxw_reg} :
    (addr == ppbc_pkg::BAUD_ADDR) ? {16'h0, baud_reg} :
    (addr == ppbc_pkg::PINS_ADDR) ? pin_word : 32'h0;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= 32'h0;
    end else begin
      rdata_reg <= rd ? rd_mux : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata = rdata_reg;
  assign status_o = status_reg;
  assign periph_reset = prst_reg;
  assign boot_src = mode_reg;
  assign program_mode = prog;
  assign debug_en = prog && !prst_reg;
endmodule
`default_nettype wire

/* logic/ppbc_shift.sv */
// Clocked serial shifter on the link clock, MSB first, full duplex.
// Assumes the clock line idles low; data change on rising edges.
`timescale 1ns/100ps
`default_nettype none
module ppbc_shift (
  // Link clock and reset
  input wire logic link_clk,
  input wire logic reset,
  // Serial data
  input wire logic rxd,
  output logic txd,
  // Toward the core
  ppbc_link_if.link lk
);
  logic [2:0] cnt_reg;
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [7:0] hold_reg;
  logic tgl_reg;

  ////////////////////////////////////////////////////////////////////
  // First bit comes straight from the held byte, so no preload edge
  assign sh_next = (cnt_reg == 3'h0) ? {lk.tx_byte[6:0], rxd}
                                     : {sh_reg[6:0], rxd};
  assign txd = (cnt_reg == 3'h0) ? lk.tx_byte[7] : sh_reg[7];
  assign lk.rx_hold = hold_reg;
  assign lk.done_tgl = tgl_reg;

  // Bit counter and shift register
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= 3'h0;
      sh_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
      sh_reg <= sh_next;
    end
  end

  // Eighth edge: park the byte and signal the core by toggle
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      hold_reg <= 8'h00;
      tgl_reg <= 1'b0;
    end else if (cnt_reg == 3'h7) begin
      hold_reg <= sh_next;
      tgl_reg <= ~tgl_reg;
    end
  end
endmodule
`default_nettype wire

/* tb/ppbc_host.sv */
// Host PC and cable model: startup pins, external reset, serial traffic.
// Assumes clk is the port's system clock; the link clock is its own.
`timescale 1ns/100ps
`default_nettype none
module ppbc_host (
  // Reference clock
  input wire logic clk,
  // Cable pins
  output logic rxd,
  output logic link_ck,
  output logic [1:0] pins,
  output logic reset_in_n,
  input wire logic txd
);
  // Cable attached at power-up: pair pulled high, line idles high
  initial begin
    rxd = 1'b1;
    link_ck = 1'b0;
    pins = 2'b11;
    reset_in_n = 1'b1;
  end
  // Pair held steady for five clocks around the reset level
  task set_reset(input logic lvl, input logic [1:0] p);
    @(posedge clk);
    pins <= p;
    reset_in_n <= lvl;
    repeat (5) @(posedge clk);
  endtask
  // Start, data LSB first, optional address bit, stop
  task send(input logic [8:0] d, input int n, input int div);
    for (int i = 0; i < n + 2; i++) begin
      @(posedge clk);
      rxd <= (i == 0) ? 1'b0 : (i > n) ? 1'b1 : d[i-1];
      repeat (div - 1) @(posedge clk);
    end
  endtask
  // Mid-bit sampling keeps clear of the port's bit edges
  task recv(output logic [8:0] d, input int n, input int div);
    d = '0;
    @(negedge txd);
    repeat (div / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (div) @(posedge clk);
      d[i] = txd;
    end
  endtask
  // Link clock runs only inside the frame; data set before each rise
  task xfer(input logic [7:0] o, output logic [7:0] g);
    #3;
    for (int i = 7; i >= 0; i--) begin
      rxd = o[i];
      #16 g[i] = txd;
      link_ck = 1'b1;
      #16 link_ck = 1'b0;
    end
    rxd = ~rxd;
  endtask
endmodule
`default_nettype wire

/* tb/ppbc_port_asserts.sv */
// Checker for the programming port, watching its top-level ports only.
// Assumes it is bound into ppbc_port and everything runs on clk.
`timescale 1ns/100ps
`default_nettype none
module ppbc_chk #(
  parameter int BOOT_DIV = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  // Pins
  input wire logic txd,
  input wire logic sclk_o,
  input wire logic sclk_oe,
  input wire logic reset_in_n,
  input wire logic status_o,
  input wire logic periph_reset,
  // Core side
  input wire logic opcode_fetch,
  input wire logic intack,
  input wire logic [1:0] boot_src,
  input wire logic program_mode,
  input wire logic debug_en
);
  logic [8:0] ctrl_q;
  logic fetched_q;
  logic async_m;
  logic [1:0] sel;
  ////////////////////////////////////////
  // Shadow control word; cleared with the peripherals
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= '0;
      fetched_q <= 1'b0;
    end else if (periph_reset) begin
      ctrl_q <= '0;
      fetched_q <= 1'b0;
    end else begin
      if (wr && addr == ppbc_pkg::CTRL_ADDR) ctrl_q <= wdata[8:0];
      if (opcode_fetch) fetched_q <= 1'b1;
    end
  end
  // Program mode forces the channel asynchronous
  assign async_m = !ctrl_q[0] || program_mode;
  assign sel = ctrl_q[5:4];
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  a_prog_pair: assert property (
    program_mode == (boot_src == 2'b11))
    else $error("program mode differs from captured pair");
  a_debug_gate: assert property (
    debug_en |-> program_mode && !periph_reset)
    else $error("debug enabled outside program mode");
  a_ext_reset: assert property (
    !reset_in_n [*5] |-> periph_reset)
    else $error("external reset not passed to peripherals");
  a_first_fetch: assert property (
    sel == 2'b00 && opcode_fetch && !fetched_q && !periph_reset
    |=> !status_o)
    else $error("status high on first fetch");
  a_ack_low: assert property (
    sel == 2'b01 && intack && !periph_reset |=> !status_o)
    else $error("status high during acknowledge");
  a_gpo_level: assert property (
    $stable(ctrl_q) && sel == 2'b10 && !periph_reset
    |-> status_o == ctrl_q[6])
    else $error("status differs from written level");
  a_clk_pin: assert property (
    $stable(ctrl_q) && async_m && !periph_reset
    |-> sclk_oe == ctrl_q[7] && (!ctrl_q[7] || sclk_o == ctrl_q[8]))
    else $error("clock pin not under general control");
  a_bit_time: assert property (
    $changed(txd) && async_m |=> $stable(txd) [*7])
    else $error("serial bit shorter than eight clocks");
  // Main scenarios reached
  c_prog: cover property (program_mode && debug_en);
  c_status: cover property (!status_o);
  c_pin: cover property (sclk_oe && sclk_o);
endmodule
`default_nettype wire

/* tb/tb.sv */
// Top bench for the programming port: host model, register tasks,
// scenarios and verdict. Assumes a shortened boot divider of 16.
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int DIV = 16;
  logic clk = 1'b0;
  logic reset, wr, rd, rxd, txd, link_ck, link_pin, sclk_o, sclk_oe;
  logic reset_in_n, status_o, periph_reset, opcode_fetch, intack;
  logic program_mode, debug_en;
  logic [1:0] pins, boot_src;
  logic [7:0] addr, hb;
  logic [8:0] hd;
  logic [31:0] wdata, rdata, v;
  int n_fail, total_checks;
  always #5 clk = ~clk;
  // Clock pin level: port drives it when enabled, else the host
  assign link_pin = sclk_oe ? sclk_o : link_ck;
  ppbc_port #(.BOOT_DIV(DIV)) u_dut (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .rxd(rxd), .txd(txd), .link_clk(link_pin), .sclk_o(sclk_o),
    .sclk_oe(sclk_oe), .startup_mode_bit0(pins[0]),
    .startup_mode_bit1(pins[1]), .reset_in_n(reset_in_n),
    .status_o(status_o), .periph_reset(periph_reset),
    .opcode_fetch(opcode_fetch), .intack(intack), .boot_src(boot_src),
    .program_mode(program_mode), .debug_en(debug_en));
  ppbc_host u_host (.clk(clk), .rxd(rxd), .link_ck(link_ck),
    .pins(pins), .reset_in_n(reset_in_n), .txd(txd));
  ////////////////////////////////////////
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////
  task t_boot;
    rd_reg(ppbc_pkg::STAT_ADDR, v);
    chk("status", 32'h1C, v);
    rd_reg(ppbc_pkg::BAUD_ADDR, v);
    chk("baud", DIV, v);
    rd_reg(ppbc_pkg::CTRL_ADDR, v);
    chk("ctrl", 32'h0, v);
    chk("boot_src", 32'h3, boot_src);
    chk("debug_en", 32'h1, debug_en);
  endtask
  task t_fetch;
    @(posedge clk) opcode_fetch <= 1'b1;
    @(posedge clk) opcode_fetch <= 1'b0;
    #1 chk("first fetch", 32'h0, status_o);
    @(posedge clk) opcode_fetch <= 1'b1;
    @(posedge clk) opcode_fetch <= 1'b0;
    #1 chk("later fetch", 32'h1, status_o);
  endtask
  task t_run;
    logic [1:0] pl [3];
    pl = '{2'b01, 2'b10, 2'b00};
    for (int i = 0; i < 3; i++) begin
      u_host.set_reset(1'b0, pl[i]);
      #1 chk("periph_reset", 32'h1, periph_reset);
      chk("debug_en", 32'h0, debug_en);
      u_host.set_reset(1'b1, pl[i]);
      #1 chk("boot_src", pl[i], boot_src);
      chk("program_mode", 32'h0, program_mode);
    end
    rd_reg(ppbc_pkg::BAUD_ADDR, v);
    chk("run baud", 32'h8, v);
  endtask
  task t_pins;
    u_host.set_reset(1'b1, 2'b10);
    wr_reg(ppbc_pkg::CTRL_ADDR, 32'h180);
    repeat (4) @(posedge clk);
    rd_reg(ppbc_pkg::PINS_ADDR, v);
    chk("pins", 32'h6, v);
    chk("clock pin", 32'h3, {sclk_oe, sclk_o});
    chk("boot kept", 32'h0, boot_src);
  endtask
  task t_status;
    wr_reg(ppbc_pkg::CTRL_ADDR, 32'h10);
    @(posedge clk) intack <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("ack low", 32'h0, status_o);
    @(posedge clk) intack <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("ack done", 32'h1, status_o);
    wr_reg(ppbc_pkg::CTRL_ADDR, 32'h20);
    repeat (2) @(posedge clk);
    #1 chk("gpo 0", 32'h0, status_o);
    wr_reg(ppbc_pkg::CTRL_ADDR, 32'h60);
    repeat (2) @(posedge clk);
    #1 chk("gpo 1", 32'h1, status_o);
  endtask
  // Divider 4 must still run at eight clocks per bit
  task t_async;
    wr_reg(ppbc_pkg::BAUD_ADDR, 32'h4);
    wr_reg(ppbc_pkg::CTRL_ADDR, 32'h0);
    fork
      u_host.recv(hd, 8, 8);
      wr_reg(ppbc_pkg::TXD_ADDR, 32'hA5);
    join
    chk("tx 8 bit", 32'hA5, hd);
    repeat (16) @(posedge clk);
    wr_reg(ppbc_pkg::CTRL_ADDR, 32'hC);
    fork
      u_host.recv(hd, 8, 8);
      wr_reg(ppbc_pkg::TXD_ADDR, 32'h135);
    join
    chk("tx 7 bit addr", 32'hB5, hd);
    repeat (16) @(posedge clk);
    wr_reg(ppbc_pkg::CTRL_ADDR, 32'h8);
    u_host.send(9'h13C, 9, 8);
    repeat (8) @(posedge clk);
    rd_reg(ppbc_pkg::STAT_ADDR, v);
    chk("rx flags", 32'h22, v & 32'h62);
    rd_reg(ppbc_pkg::RXD_ADDR, v);
    chk("rx addr data", 32'h13C, v & 32'h1FF);
  endtask
  task t_clocked;
    wr_reg(ppbc_pkg::CTRL_ADDR, 32'h1);
    wr_reg(ppbc_pkg::TXD_ADDR, 32'h96);
    repeat (4) @(posedge clk);
    u_host.xfer(8'h3C, hb);
    chk("link tx", 32'h96, hb);
    repeat (10) @(posedge clk);
    rd_reg(ppbc_pkg::RXD_ADDR, v);
    chk("link rx", 32'h3C, v & 32'hFF);
  endtask
  ////////////////////////////////////////
  // Watchdog sized well past the whole sequence
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("BAD watchdog exp finish got timeout");
    end_of_test;
  end
  initial begin
    reset = 1'b1;
    addr = 8'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    opcode_fetch = 1'b0;
    intack = 1'b0;
    n_fail = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    t_boot;
    t_fetch;
    t_run;
    t_pins;
    t_status;
    t_async;
    t_clocked;
    end_of_test;
  end
endmodule
bind ppbc_port ppbc_chk #(.BOOT_DIV(BOOT_DIV)) u_chk (.clk(clk),
  .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .txd(txd),
  .sclk_o(sclk_o), .sclk_oe(sclk_oe), .reset_in_n(reset_in_n),
  .status_o(status_o), .periph_reset(periph_reset),
  .opcode_fetch(opcode_fetch), .intack(intack), .boot_src(boot_src),
  .program_mode(program_mode), .debug_en(debug_en));
`default_nettype wire
